// File: hdl/dpll_ref_select_state_ctrl.sv
// Per-loop state control, reference selection and status pin routing
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module loop_state_ctrl #(
  parameter int SHORT_CYC = ref_sel_pkg::LOCK_SHORT_CYC,
  parameter int LONG_CYC = ref_sel_pkg::LOCK_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire ref_sel_pkg::ref_mon_t [3:0] mon_in,
  input wire ref_sel_pkg::loop_ctrl_t ctrl_in,
  input wire ref_sel_pkg::mask_cfg_t mask_in,
  input wire ref_sel_pkg::prio_t prio_in,
  input wire logic [15:0] range_in,
  input wire logic [31:0] phase_err_in,
  input wire logic [15:0] freq_off_in,
  output ref_sel_pkg::loop_status_t status_out
);
  import ref_sel_pkg::*;
  localparam logic [3:0][31:0] ERR_NS = {32'(LOCK3_ERR_US * NS_PER_US),
    32'(LOCK2_ERR_US * NS_PER_US), 32'(LOCK1_ERR_US * NS_PER_US),
    32'(LOCK0_ERR_US * NS_PER_US)};
  localparam logic [3:0][31:0] PER = {32'(LONG_CYC), 32'(SHORT_CYC),
    32'(SHORT_CYC), 32'(LONG_CYC)};
  loop_state_t st_r, st_nxt;
  logic [1:0] cur_r, cur_nxt, best;
  logic [3:0] fail_sw, fail_ho, avail, lock_r;
  logic [2:0] pick;
  logic found, sw_need, force_ok, norm_r, hold_r, oor_r;
  logic [3:0][31:0] cnt_r;

  // Best available input: lowest priority value, lowest index on ties
  function automatic logic [2:0] pick_best(prio_t p, logic [3:0] ok);
    logic [2:0] res;
    logic [2:0] bp;
    res = 3'h0;
    bp = PRIO_OFF;
    for (int i = 3; i >= 0; i--) begin
      if (ok[i] && (!res[2] || p[i] <= bp)) begin
        res = {1'b1, 2'(i)};
        bp = p[i];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Failure qualification
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fail_sw[i] = (|(mon_in[i][3:0] & mask_in.switch_trigger_mask)) |
        (mon_in[i].precise_freq_monitor & mask_in.precise_freq_switch_mask);
      fail_ho[i] = (|(mon_in[i][3:0] & mask_in.holdover_trigger_mask)) |
        (mon_in[i].precise_freq_monitor & mask_in.precise_freq_holdover_mask);
      avail[i] = !fail_sw[i] && !fail_ho[i] && prio_in[i] != PRIO_OFF;
    end
  end
  assign pick = pick_best(prio_in, avail);
  assign found = pick[2];
  assign best = pick[1:0];
  assign sw_need = fail_sw[cur_r] || prio_in[cur_r] == PRIO_OFF ||
    (found && prio_in[best] < prio_in[cur_r]);
  assign force_ok = !fail_sw[ctrl_in.force_ref] && !fail_ho[ctrl_in.force_ref];

  ////////////////////////////////////////////////////////////////////////////////
  // State and reference decision
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    if (ctrl_in.managed) begin
      cur_nxt = ctrl_in.force_ref;
      unique case (ctrl_in.force_state)
        REQ_NORMAL: begin
          if (ctrl_in.force_ref != cur_r || !force_ok) begin
            st_nxt = ST_AUTO;
          end else begin
            st_nxt = ST_NORM;
          end
        end
        REQ_HOLD: st_nxt = ST_HOLD;
        default: st_nxt = ST_FREE;
      endcase
    end else if (st_r == ST_FREE && !found) begin
      st_nxt = ST_FREE;
    end else if (sw_need) begin
      if (found) begin
        cur_nxt = best;
        st_nxt = ST_NORM;
      end else begin
        st_nxt = ST_AUTO;
      end
    end else if (fail_ho[cur_r]) begin
      st_nxt = ST_AUTO;
    end else begin
      st_nxt = ST_NORM;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= ST_FREE;
      cur_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Published status
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      norm_r <= 1'b0;
      hold_r <= 1'b0;
      oor_r <= 1'b0;
    end else begin
      norm_r <= st_nxt == ST_NORM;
      hold_r <= st_nxt == ST_HOLD || st_nxt == ST_AUTO;
      oor_r <= freq_off_in > range_in;
    end
  end

  // Lock qualifiers: error must stay under threshold for a whole period
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
      lock_r <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (phase_err_in >= ERR_NS[k]) begin
          cnt_r[k] <= 32'h0;
          lock_r[k] <= 1'b0;
        end else begin
          if (cnt_r[k] < PER[k] - 32'h1) begin
            cnt_r[k] <= cnt_r[k] + 32'h1;
          end
          lock_r[k] <= cnt_r[k] >= PER[k] - 32'h1;
        end
      end
    end
  end
  assign status_out = '{lock: lock_r, out_of_range: oor_r, used_ref: cur_r,
    holdover: hold_r, normal: norm_r};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_used_ref_pub: assert property (
    ctrl_in.managed |=> status_out.used_ref == $past(ctrl_in.force_ref))
    else $error("used reference not published");
  chk_range_flag: assert property (
    freq_off_in > range_in |=> status_out.out_of_range)
    else $error("out of range flag missing");
  chk_lock0_err: assert property (
    phase_err_in >= ERR_NS[0] |=> !status_out.lock[0] ##1 !status_out.lock[0])
    else $error("lock zero held over large error");
  chk_lock1_err: assert property (
    phase_err_in >= ERR_NS[1] |=> !status_out.lock[1])
    else $error("lock one held over large error");
  chk_lock2_err: assert property (
    phase_err_in >= ERR_NS[2] |=> !status_out.lock[2])
    else $error("lock two held over large error");
  chk_lock3_err: assert property (
    phase_err_in >= ERR_NS[3] |=> !status_out.lock[3])
    else $error("lock three held over large error");
  chk_switch_best: assert property (
    !ctrl_in.managed && st_r == ST_NORM && fail_sw[cur_r] && found
    |=> cur_r == $past(best) && st_r == ST_NORM)
    else $error("switch did not take best input");
  chk_auto_enter: assert property (
    !ctrl_in.managed && st_r != ST_FREE && fail_ho[cur_r] && !sw_need
    |=> st_r == ST_AUTO && status_out.holdover)
    else $error("auto holdover not entered");
  chk_all_failed: assert property (
    !ctrl_in.managed && st_r != ST_FREE && sw_need && !found
    |=> st_r == ST_AUTO && $stable(cur_r))
    else $error("reference changed with none available");
  chk_auto_leave: assert property (
    !ctrl_in.managed && st_r == ST_AUTO && !sw_need && !fail_ho[cur_r]
    |=> st_r == ST_NORM)
    else $error("auto holdover not left");
  chk_equal_stay: assert property (
    !ctrl_in.managed && st_r == ST_NORM && avail[cur_r] && found &&
    prio_in[best] == prio_in[cur_r] |=> $stable(cur_r))
    else $error("revert between equal priorities");
  chk_mgd_refchg: assert property (
    ctrl_in.managed && ctrl_in.force_state == REQ_NORMAL &&
    ctrl_in.force_ref != cur_r |=> st_r == ST_AUTO)
    else $error("reference change skipped holdover");
  chk_mgd_badref: assert property (
    ctrl_in.managed && ctrl_in.force_state == REQ_NORMAL && !force_ok
    |=> st_r == ST_AUTO)
    else $error("locked to failed reference");

  cov_switch: cover property (st_r == ST_NORM && fail_sw[cur_r] && found);
  cov_auto_ho: cover property (st_r == ST_NORM ##1 st_r == ST_AUTO);
  cov_mgd_change: cover property (ctrl_in.managed && ctrl_in.force_ref != cur_r);
  cov_lock: cover property ($rose(status_out.lock[1]));
endmodule // loop_state_ctrl

////////////////////////////////////////////////////////////////////////////////
module dpll_ref_select_state_ctrl #(
  parameter int GPIO_N = 4,
  parameter int SHORT_CYC = ref_sel_pkg::LOCK_SHORT_CYC,
  parameter int LONG_CYC = ref_sel_pkg::LOCK_LONG_CYC
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire ref_sel_pkg::ref_mon_t [3:0] mon_in,
  input wire logic [1:0][31:0] phase_err_in,
  input wire logic [1:0][15:0] freq_off_in,
  output ref_sel_pkg::loop_status_t [1:0] status_out,
  output logic [GPIO_N-1:0] gpio_out
);
  import ref_sel_pkg::*;
  loop_ctrl_t [1:0] ctrl_r;
  mask_cfg_t [1:0] mask_r;
  prio_t [1:0] prio_r;
  logic [1:0][15:0] range_r, doc_vec, own_vec;
  logic [GPIO_N-1:0][7:0] gpio_sel_r;
  logic [15:0] rd_mux;

  function automatic logic [7:0] loop_addr(int l, logic [7:0] ofs);
    return (l == 1) ? ofs + LOOP_STRIDE : ofs;
  endfunction

  // Status pin selector: code windows per loop
  function automatic logic gpio_pick(logic [7:0] c, logic [1:0][15:0] dv,
                                     logic [1:0][15:0] ov);
    logic r;
    logic [7:0] d;
    logic [7:0] o;
    r = 1'b0;
    for (int l = 0; l < 2; l++) begin
      d = c - GPIO_DOC_BASE[l];
      o = c - GPIO_OWN_BASE[l];
      if (d < GPIO_SPAN) begin
        r = dv[l][d[3:0]];
      end
      if (o < GPIO_SPAN) begin
        r = ov[l][o[3:0]];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= {2{CTRL_RST}};
      mask_r <= {2{MASK_RST}};
      prio_r <= {2{PRIO_RST}};
      range_r <= {2{RANGE_RST}};
      gpio_sel_r <= '0;
    end else if (wr_in) begin
      for (int l = 0; l < 2; l++) begin
        if (addr_in == loop_addr(l, OFS_CTRL)) ctrl_r[l] <= loop_ctrl_t'(wr_data_in[5:0]);
        if (addr_in == loop_addr(l, OFS_MASK)) mask_r[l] <= mask_cfg_t'(wr_data_in[9:0]);
        if (addr_in == loop_addr(l, OFS_PRIO)) prio_r[l] <= prio_t'(wr_data_in[11:0]);
        if (addr_in == loop_addr(l, OFS_RANGE)) range_r[l] <= wr_data_in;
      end
      for (int g = 0; g < GPIO_N; g++) begin
        if (addr_in == OFS_GPIO + 8'(g)) gpio_sel_r[g] <= wr_data_in[7:0];
      end
    end
  end

  // Register reads, data in the following cycle only
  always_comb begin
    rd_mux = 16'h0000;
    for (int l = 0; l < 2; l++) begin
      if (addr_in == loop_addr(l, OFS_CTRL)) rd_mux = 16'(ctrl_r[l]);
      if (addr_in == loop_addr(l, OFS_MASK)) rd_mux = 16'(mask_r[l]);
      if (addr_in == loop_addr(l, OFS_PRIO)) rd_mux = 16'(prio_r[l]);
      if (addr_in == loop_addr(l, OFS_RANGE)) rd_mux = range_r[l];
      if (addr_in == loop_addr(l, OFS_STAT)) rd_mux = 16'(status_out[l]);
    end
    for (int g = 0; g < GPIO_N; g++) begin
      if (addr_in == OFS_GPIO + 8'(g)) rd_mux = {8'h00, gpio_sel_r[g]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      rd_data_out <= rd_in ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two independent loops
  for (genvar l = 0; l < 2; l++) begin : g_loop
    loop_state_ctrl #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
    ) u_loop (
      .clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .mon_in(mon_in),
      .ctrl_in(ctrl_r[l]),
      .mask_in(mask_r[l]),
      .prio_in(prio_r[l]),
      .range_in(range_r[l]),
      .phase_err_in(phase_err_in[l]),
      .freq_off_in(freq_off_in[l]),
      .status_out(status_out[l])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status pin routing
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      doc_vec[l] = {5'h00, status_out[l].lock, 1'b0, status_out[l].out_of_range, 1'b0,
        status_out[l].used_ref[0], status_out[l].used_ref[1],
        status_out[l].holdover, status_out[l].normal};
      own_vec[l] = {8'h00, mon_in[status_out[l].used_ref][2:0],
        ctrl_r[l].hitless, ctrl_r[l].force_ref[0], ctrl_r[l].force_ref[1],
        ctrl_r[l].force_state[0], ctrl_r[l].force_state[1]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gpio_out <= '0;
    end else begin
      for (int g = 0; g < GPIO_N; g++) begin
        gpio_out[g] <= gpio_pick(gpio_sel_r[g], doc_vec, own_vec);
      end
    end
  end
endmodule // dpll_ref_select_state_ctrl

`default_nettype wire

// File: hdl/ref_sel_pkg.sv
// Package: constants and types for the loop state and reference selector
`default_nettype none
package ref_sel_pkg;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int LOCK_SHORT_S = 1;
  localparam int LOCK_LONG_S = 10;
  localparam int LOCK_SHORT_CYC = LOCK_SHORT_S * CLK_HZ;
  localparam int LOCK_LONG_CYC = LOCK_LONG_S * CLK_HZ;
  localparam int NS_PER_US = 1000;
  localparam int LOCK0_ERR_US = 36;
  localparam int LOCK1_ERR_US = 1;
  localparam int LOCK2_ERR_US = 10;
  localparam int LOCK3_ERR_US = 10;
  localparam logic [2:0] PRIO_OFF = 3'h7;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h01;
  localparam logic [7:0] OFS_PRIO = 8'h02;
  localparam logic [7:0] OFS_RANGE = 8'h03;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] LOOP_STRIDE = 8'h08;
  localparam logic [7:0] OFS_GPIO = 8'h10;
  // Status pin function codes, two windows of sixteen per loop
  localparam logic [1:0][7:0] GPIO_DOC_BASE = {8'hb8, 8'ha8};
  localparam logic [1:0][7:0] GPIO_OWN_BASE = {8'hf0, 8'he0};
  localparam logic [7:0] GPIO_SPAN = 8'h10;
  // Requested state in managed mode
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_HOLD = 2'h1;
  localparam logic [1:0] REQ_FREE = 2'h2;
  typedef struct packed {
    logic precise_freq_monitor;
    logic guard_soak_timer;
    logic coarse_freq_monitor;
    logic single_cycle_monitor;
    logic signal_loss_flag;
  } ref_mon_t;
  typedef struct packed {
    logic hitless; logic [1:0] force_ref; logic [1:0] force_state; logic managed;
  } loop_ctrl_t;
  typedef struct packed {
    logic precise_freq_holdover_mask;
    logic precise_freq_switch_mask;
    logic [3:0] holdover_trigger_mask;
    logic [3:0] switch_trigger_mask;
  } mask_cfg_t;
  typedef logic [3:0][2:0] prio_t;
  typedef struct packed {
    logic [3:0] lock; logic out_of_range; logic [1:0] used_ref;
    logic holdover; logic normal;
  } loop_status_t;
  typedef enum logic [3:0] {
    ST_FREE = 4'b0001, ST_NORM = 4'b0010, ST_HOLD = 4'b0100, ST_AUTO = 4'b1000
  } loop_state_t;
  localparam loop_ctrl_t CTRL_RST = '{1'b0, 2'h0, 2'h0, 1'b0};
  localparam mask_cfg_t MASK_RST = '{precise_freq_holdover_mask: 1'b1,
    precise_freq_switch_mask: 1'b0, holdover_trigger_mask: 4'h7, switch_trigger_mask: 4'h8};
  localparam prio_t PRIO_RST = 12'h688;
  localparam logic [15:0] RANGE_RST = 16'h0100;
endpackage
`default_nettype wire

// File: verification/host_ctrl_model.sv
// Host controller model driving the register port
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module host_ctrl_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [15:0] wr_data_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [15:0] rd_data_in
);
  initial begin
    addr_out = 8'h00;
    wr_data_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Released bus shows inverted values
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask

  // Managed mode: forces state and input of one loop
  task automatic force_loop(input logic [7:0] base, input logic [5:0] c);
    write_reg(base, {10'h000, c});
  endtask
endmodule // host_ctrl_model
`default_nettype wire

// File: verification/dpll_ref_select_state_ctrl_bench.sv
// Self-checking bench for the loop state and reference selector
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dpll_ref_select_state_ctrl_bench;
  import ref_sel_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG = 50;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr;
  logic [15:0] wr_data;
  logic wr;
  logic rd;
  logic [15:0] rd_data;
  ref_mon_t [3:0] mon = '0;
  logic [1:0][31:0] perr = {32'hffffffff, 32'hffffffff};
  logic [1:0][15:0] foff = '0;
  loop_status_t [1:0] stat;
  logic [3:0] gpio;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] v;

  always #12.5 ref_clk = ~ref_clk;

  host_ctrl_model host (.clk_in(ref_clk), .addr_out(addr), .wr_data_out(wr_data),
    .wr_out(wr), .rd_out(rd), .rd_data_in(rd_data));
  dpll_ref_select_state_ctrl #(.GPIO_N(4), .SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (
    .ref_clk_in(ref_clk), .resetn_in(resetn), .addr_in(addr), .wr_data_in(wr_data),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .mon_in(mon), .phase_err_in(perr),
    .freq_off_in(foff), .status_out(stat), .gpio_out(gpio));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic put_mon(input logic [19:0] m);
    @(posedge ref_clk);
    mon <= m;
    settle(3);
  endtask

  function automatic logic [15:0] st(input int lp);
    return {7'h00, stat[lp]};
  endfunction

  // Status word with locks and range flag clear
  function automatic logic [15:0] es(input logic n, input logic h, input logic [1:0] r);
    return {12'h000, r, h, n};
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host.read_reg(a, v);
    check(v, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(st(0), es(1'h1, 1'h0, 2'h0));
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h01, 16'h0278);
    rd_chk(8'h09, 16'h0278);
    rd_chk(8'h02, 16'h0688);
    rd_chk(8'h03, 16'h0100);
    @(negedge ref_clk);
    check(rd_data, 16'h0000);
    host.write_reg(8'h04, 16'hffff);
    host.write_reg(8'h0f, 16'h1234);
    rd_chk(8'h04, es(1'h1, 1'h0, 2'h0));
    rd_chk(8'h0f, 16'h0000);
  endtask

  task automatic t_switch();
    logic [15:0] masks [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0100};
    for (int k = 0; k < 5; k++) begin
      host.write_reg(8'h01, masks[k]);
      put_mon(20'(1 << k));
      check(st(0), es(1'h1, 1'h0, 2'h1));
      put_mon(20'(1 << ((k + 1) % 5)));
      check(st(0), es(1'h1, 1'h0, 2'h0));
    end
    put_mon(20'h00000);
    host.write_reg(8'h01, 16'h0278);
  endtask

  task automatic t_prio();
    host.write_reg(8'h02, 16'h0257);
    settle(2);
    check(st(0), es(1'h1, 1'h0, 2'h2));
    put_mon(20'h02000);
    check(st(0), es(1'h1, 1'h0, 2'h3));
    put_mon(20'h00000);
    check(st(0), es(1'h1, 1'h0, 2'h3));
    host.write_reg(8'h02, 16'h0247);
    settle(2);
    check(st(0), es(1'h1, 1'h0, 2'h1));
    host.write_reg(8'h02, 16'h0688);
    settle(2);
  endtask

  task automatic t_hold();
    host.write_reg(8'h09, 16'h0000);
    put_mon(20'h00001);
    check(st(0), es(1'h0, 1'h1, 2'h0));
    check(st(1), es(1'h1, 1'h0, 2'h0));
    put_mon(20'h00000);
    check(st(0), es(1'h1, 1'h0, 2'h0));
    host.write_reg(8'h09, 16'h0278);
    put_mon(20'h42108);
    check(st(0), es(1'h0, 1'h1, 2'h0));
    put_mon(20'h00000);
    check(st(0), es(1'h1, 1'h0, 2'h0));
  endtask

  task automatic t_managed();
    logic seen_h;
    seen_h = 1'b0;
    host.write_reg(8'h02, 16'h0000);
    host.force_loop(8'h00, 6'h11);
    repeat (4) begin
      @(negedge ref_clk);
      seen_h = seen_h | stat[0].holdover;
    end
    check({15'h0000, seen_h}, 16'h0001);
    check(st(0), es(1'h1, 1'h0, 2'h2));
    host.force_loop(8'h00, 6'h13);
    settle(2);
    check(st(0), es(1'h0, 1'h1, 2'h2));
    host.force_loop(8'h00, 6'h15);
    settle(2);
    check(st(0) & 16'h0003, 16'h0000);
    put_mon(20'h40000);
    host.force_loop(8'h00, 6'h19);
    settle(3);
    check(st(0) & 16'h0003, 16'h0002);
    put_mon(20'h00000);
    check(st(0), es(1'h1, 1'h0, 2'h3));
    host.force_loop(8'h00, 6'h11);
    settle(4);
    host.write_reg(8'h00, 16'h0010);
    settle(3);
    check(st(0), es(1'h1, 1'h0, 2'h2));
    host.write_reg(8'h02, 16'h0688);
    settle(3);
  endtask

  task automatic t_gpio();
    logic [7:0] code [11] = '{8'haa, 8'hab, 8'ha8, 8'ha9, 8'he2, 8'he3, 8'he4, 8'he1,
      8'hb8, 8'hba, 8'hac};
    logic [10:0] ev = 11'b00101110111;
    host.force_loop(8'h00, 6'h39);
    settle(3);
    rd_chk(8'h04, 16'h000d);
    for (int k = 0; k < 11; k++) begin
      host.write_reg(8'h10 + 8'(k % 4), {8'h00, code[k]});
      settle(2);
      check({15'h0000, gpio[k % 4]}, {15'h0000, ev[k]});
    end
    host.write_reg(8'h00, 16'h0000);
    settle(3);
  endtask

  task automatic t_range();
    @(posedge ref_clk);
    foff[0] <= 16'h0100;
    settle(2);
    check(st(0), es(1'h1, 1'h0, 2'h0));
    @(posedge ref_clk);
    foff[0] <= 16'h0101;
    settle(2);
    check({15'h0000, stat[0].out_of_range}, 16'h0001);
    host.write_reg(8'h03, 16'h0101);
    settle(2);
    check({15'h0000, stat[0].out_of_range}, 16'h0000);
    @(posedge ref_clk);
    foff[0] <= 16'h0000;
  endtask

  task automatic t_lock();
    @(posedge ref_clk);
    perr[0] <= 32'd5000;
    settle(25);
    check({12'h000, stat[0].lock}, 16'h0004);
    settle(30);
    check({12'h000, stat[0].lock}, 16'h000d);
    @(posedge ref_clk);
    perr[0] <= 32'd500;
    settle(55);
    check({12'h000, stat[0].lock}, 16'h000f);
    @(posedge ref_clk);
    perr[0] <= 32'd20000;
    settle(2);
    check({12'h000, stat[0].lock}, 16'h0001);
    check({12'h000, stat[1].lock}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    settle(4);
    t_reset();
    t_switch();
    t_prio();
    t_hold();
    t_managed();
    t_gpio();
    t_range();
    t_lock();
    give_verdict();
  end
endmodule // dpll_ref_select_state_ctrl_bench
`default_nettype wire
